// [link_partner_model.sv]
`timescale 1ns/1ps
module link_partner_model (
   // Clock
   input  wire logic                    core_clk,
   // Received base page
   output logic                         partner_word_valid,
   output phy_ident_pkg::reg_word_type  partner_word
);
   import phy_ident_pkg::*;
   reg_word_type last_r;
   initial begin
      partner_word_valid = 1'b0;
      last_r             = 16'h0000;
      partner_word       = 16'hffff;
   end
   // One-cycle code word, then the bus shows the inverse of the last word
   task automatic send(input reg_word_type word);
      @(posedge core_clk);
      #1;
      partner_word_valid = 1'b1;
      partner_word       = word;
      last_r             = word;
      @(posedge core_clk);
      #1;
      partner_word_valid = 1'b0;
      partner_word       = ~last_r;
   endtask : send
endmodule : link_partner_model

// [phy_ident_autoneg_ability_regs.sv]
// Function
// - High identifier word is organization identifier bits 21:6, read-only.
// - Low identifier word bits 15:10 hold organization identifier bits 5:0.
// - Model number in bits 9:4 differs between basic and enhanced mode.
// - Revision number in bits 3:0, bumped per major device change.
// - Advert bit 15 is a writable next-page request, reset zero.
// - Advert bits 11 and 10 are writable pause abilities, reset zero.
// - Advert bit 9, four-pair ability, is read-only zero.
// - Bits 8:6 writable, default one, strapped in basic mode only.
// - Bit 5 writable, default one, strapped in both modes.
// - Bits 4:0 writable selector, reset 00001.
// - Partner bit 15 shows partner next-page request, reset zero.
// - Partner bit 14 shows partner acknowledge of local code word.
// - Partner bit 13 shows partner remote fault advertisement.
// - Partner bits 11:10 capture partner asymmetric and symmetric pause.
// - Partner bits 9:6 capture four-pair and duplex speed abilities.
// - Partner bit 5 and selector 4:0 captured; read-only, reset zero.
`timescale 1ns/1ps
`include "phy_ident_map.svh"

module phy_ident_autoneg_ability_regs #(
   parameter logic [15:0] OUI_HIGH       = 16'h1234, // Arbitrary value
   parameter logic [5:0]  OUI_LOW        = 6'h15,    // Arbitrary value
   parameter logic [5:0]  MODEL_BASIC    = 6'h05,    // Arbitrary value
   parameter logic [5:0]  MODEL_ENHANCED = 6'h06,    // Arbitrary value
   parameter logic [3:0]  REVISION       = 4'h1      // Arbitrary value
) (
   // Clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   // Bootstrap pins and mode
   input  wire phy_ident_pkg::pin_mode_type pin_mode,
   input  wire logic                        strap_load,
   input  wire logic                        strap_tx_fd,
   input  wire logic                        strap_tx_hd,
   input  wire logic                        strap_10_fd,
   input  wire logic                        strap_10_hd,
   // Management register access
   input  wire phy_ident_pkg::reg_index_type reg_addr,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   input  wire phy_ident_pkg::reg_word_type reg_wdata,
   output logic [15:0]                      reg_rdata,
   output logic                             reg_rvalid,
   // Partner code word from arbitration
   input  wire logic                        partner_word_valid,
   input  wire phy_ident_pkg::reg_word_type partner_word,
   // Advertised word toward arbitration
   output logic [15:0]                      advert_word
);
   import phy_ident_pkg::*;

   // ****************************************************************
   // Local advertisement word
   // ****************************************************************
   reg_word_type advert_r;
   reg_word_type partner_r;
   reg_word_type ident_low;
   reg_word_type rdata_nxt;
   logic         adv_wr;

   assign adv_wr = reg_wr && (reg_addr == `LOCAL_ADVERT_IDX);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         advert_r <= `LOCAL_ADVERT_RST;
      end else if (adv_wr) begin
         // Only writable bits take the write
         advert_r <= reg_wdata & `LOCAL_ADVERT_WMASK;
      end else if (strap_load) begin
         advert_r[`ADV_10_HD_BIT] <= strap_10_hd;
         if (pin_mode == PIN_MODE_BASIC) begin
            advert_r[`ADV_TX_FD_BIT] <= strap_tx_fd;
            advert_r[`ADV_TX_HD_BIT] <= strap_tx_hd;
            advert_r[`ADV_10_FD_BIT] <= strap_10_fd;
         end
      end
   end

   // ****************************************************************
   // Advertisement checks
   // ****************************************************************
   advert_ro_zero_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      advert_r[`ADV_RSVD_HI_BIT] == 1'b0 &&
      advert_r[`ADV_RSVD_LO_BIT] == 1'b0 &&
      advert_r[`ADV_T4_BIT] == 1'b0)
      else $error("read-only advert bits not zero");

   advert_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv_wr |=> advert_r == ($past(reg_wdata) & `LOCAL_ADVERT_WMASK))
      else $error("advert write not stored");

   next_page_wr_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv_wr |=> advert_r[`ADV_NEXT_PAGE_BIT] ==
                 $past(reg_wdata[`ADV_NEXT_PAGE_BIT]))
      else $error("next page bit not written");

   pause_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv_wr |=> advert_r[`ADV_ASYM_PAUSE_BIT:`ADV_PAUSE_BIT] ==
                 $past(reg_wdata[`ADV_ASYM_PAUSE_BIT:`ADV_PAUSE_BIT]))
      else $error("pause bits not written");

   advert_duplex_wr_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv_wr |=> advert_r[`ADV_TX_FD_BIT:`ADV_10_HD_BIT] ==
                 $past(reg_wdata[`ADV_TX_FD_BIT:`ADV_10_HD_BIT]))
      else $error("duplex ability bits not written");

   selector_wr_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      adv_wr |=> advert_r[`ADV_SEL_MSB:`ADV_SEL_LSB] ==
                 $past(reg_wdata[`ADV_SEL_MSB:`ADV_SEL_LSB]))
      else $error("selector field not written");

   strap_hd_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      strap_load && !adv_wr |=>
      advert_r[`ADV_10_HD_BIT] == $past(strap_10_hd))
      else $error("strap half duplex not loaded");

   strap_basic_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      strap_load && !adv_wr && pin_mode == PIN_MODE_BASIC |=>
      advert_r[`ADV_TX_FD_BIT:`ADV_10_FD_BIT] ==
      $past({strap_tx_fd, strap_tx_hd, strap_10_fd}))
      else $error("basic straps not loaded");

   strap_enh_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      strap_load && !adv_wr && pin_mode == PIN_MODE_ENHANCED |=>
      $stable(advert_r[`ADV_TX_FD_BIT:`ADV_10_FD_BIT]))
      else $error("enhanced mode loaded basic straps");

   strap_rest_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      strap_load && !adv_wr |=>
      $stable(advert_r[`ADV_NEXT_PAGE_BIT:`ADV_T4_BIT]) &&
      $stable(advert_r[`ADV_SEL_MSB:`ADV_SEL_LSB]))
      else $error("strap load touched unstrapped bits");

   advert_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !adv_wr && !strap_load |=> $stable(advert_r))
      else $error("advert word changed unprompted");

   // ****************************************************************
   // Partner ability word
   // ****************************************************************
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         partner_r <= `PARTNER_ABIL_RST;
      end else if (partner_word_valid) begin
         // Reserved bit 12 dropped
         partner_r <= partner_word & `PARTNER_ABIL_MASK;
      end
   end

   // ****************************************************************
   // Partner checks
   // ****************************************************************
   partner_cap_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=>
      partner_r == ($past(partner_word) & `PARTNER_ABIL_MASK))
      else $error("partner word not captured");

   partner_np_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=> partner_r[`PARTNER_NEXT_PAGE_BIT] ==
      $past(partner_word[`PARTNER_NEXT_PAGE_BIT]))
      else $error("partner next page not captured");

   partner_ack_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=> partner_r[`PARTNER_ACK_BIT] ==
      $past(partner_word[`PARTNER_ACK_BIT]))
      else $error("partner acknowledge not captured");

   partner_rf_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=> partner_r[`PARTNER_REM_FAULT_BIT] ==
      $past(partner_word[`PARTNER_REM_FAULT_BIT]))
      else $error("partner remote fault not captured");

   partner_pause_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=> partner_r[`ADV_ASYM_PAUSE_BIT:`ADV_PAUSE_BIT] ==
      $past(partner_word[`ADV_ASYM_PAUSE_BIT:`ADV_PAUSE_BIT]))
      else $error("partner pause bits not captured");

   partner_sel_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_word_valid |=> partner_r[`ADV_10_HD_BIT:`ADV_SEL_LSB] ==
      $past(partner_word[`ADV_10_HD_BIT:`ADV_SEL_LSB]))
      else $error("partner low field not captured");

   partner_rsvd_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      partner_r[`PARTNER_RSVD_BIT] == 1'b0)
      else $error("partner reserved bit set");

   partner_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !partner_word_valid |=> $stable(partner_r))
      else $error("partner word changed unprompted");

   partner_wr_ign_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_wr && !partner_word_valid |=> $stable(partner_r))
      else $error("partner word took a register write");

   // ****************************************************************
   // Read path
   // ****************************************************************
   always_comb begin
      ident_low = {OUI_LOW,
                   (pin_mode == PIN_MODE_BASIC) ?
                      MODEL_BASIC : MODEL_ENHANCED,
                   REVISION};
      unique case (reg_addr)
         `IDENT_HIGH_IDX:   rdata_nxt = OUI_HIGH;
         `IDENT_LOW_IDX:    rdata_nxt = ident_low;
         `LOCAL_ADVERT_IDX: rdata_nxt = advert_r;
         `PARTNER_ABIL_IDX: rdata_nxt = partner_r;
         default:           rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rdata_nxt;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         advert_word <= `LOCAL_ADVERT_RST;
      end else begin
         advert_word <= advert_r;
      end
   end

   // ****************************************************************
   // Read path and output checks
   // ****************************************************************
   ident_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `IDENT_HIGH_IDX |=>
      reg_rvalid && reg_rdata == OUI_HIGH)
      else $error("identifier high read wrong");

   ident_low_basic_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `IDENT_LOW_IDX && pin_mode == PIN_MODE_BASIC
      |=> reg_rdata == {OUI_LOW, MODEL_BASIC, REVISION})
      else $error("identifier low basic read wrong");

   model_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `IDENT_LOW_IDX && pin_mode == PIN_MODE_ENHANCED
      |=> reg_rdata[9:4] == MODEL_ENHANCED && reg_rdata[3:0] == REVISION)
      else $error("model or revision read wrong");

   advert_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `LOCAL_ADVERT_IDX |=>
      reg_rdata == $past(advert_r))
      else $error("advert read wrong");

   partner_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && reg_addr == `PARTNER_ABIL_IDX |=>
      reg_rdata == $past(partner_r))
      else $error("partner read wrong");

   unmapped_read_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      reg_rd && (reg_addr < `IDENT_HIGH_IDX || reg_addr > `PARTNER_ABIL_IDX)
      |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");

   read_valid_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> reg_rvalid == $past(reg_rd))
      else $error("read valid not one cycle after read");

   rdata_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   advert_copy_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> advert_word == $past(advert_r))
      else $error("advert output does not follow register");

endmodule : phy_ident_autoneg_ability_regs

// [phy_ident_map.svh]
`ifndef PHY_IDENT_MAP_SVH
`define PHY_IDENT_MAP_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define IDENT_HIGH_IDX      5'h02
`define IDENT_LOW_IDX       5'h03
`define LOCAL_ADVERT_IDX    5'h04
`define PARTNER_ABIL_IDX    5'h05

// ****************************************************************
// Field positions
// ****************************************************************
`define ADV_NEXT_PAGE_BIT   15
`define ADV_REM_FAULT_BIT   13
`define ADV_ASYM_PAUSE_BIT  11
`define ADV_PAUSE_BIT       10
`define ADV_T4_BIT          9
`define ADV_TX_FD_BIT       8
`define ADV_TX_HD_BIT       7
`define ADV_10_FD_BIT       6
`define ADV_10_HD_BIT       5
`define ADV_SEL_MSB         4
`define ADV_SEL_LSB         0
`define ADV_RSVD_HI_BIT     14
`define ADV_RSVD_LO_BIT     12
// Partner word shares the advert layout apart from these
`define PARTNER_NEXT_PAGE_BIT 15
`define PARTNER_ACK_BIT     14
`define PARTNER_REM_FAULT_BIT 13
`define PARTNER_RSVD_BIT    12

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define LOCAL_ADVERT_RST    16'h01e1
`define LOCAL_ADVERT_WMASK  16'hadff
`define PARTNER_ABIL_MASK   16'hefff
`define PARTNER_ABIL_RST    16'h0000

`endif

// [phy_ident_pkg.sv]
package phy_ident_pkg;
   typedef logic [15:0] reg_word_type;
   typedef logic [4:0]  reg_index_type;
   typedef enum logic [1:0] {
      PIN_MODE_BASIC    = 2'b01,
      PIN_MODE_ENHANCED = 2'b10
   } pin_mode_type;
endpackage : phy_ident_pkg

// [testbench.sv]
`timescale 1ns/1ps
`include "phy_ident_map.svh"
module testbench;
   import phy_ident_pkg::*;
   localparam logic [15:0] OUI_H = 16'h4a5b; // Arbitrary value
   localparam logic [5:0]  OUI_L = 6'h2c;    // Arbitrary value
   localparam logic [5:0]  MOD_B = 6'h09;    // Arbitrary value
   localparam logic [5:0]  MOD_E = 6'h0a;    // Arbitrary value
   localparam logic [3:0]  REV   = 4'h3;     // Arbitrary value
   logic core_clk, rst_n, strap_load, reg_wr, reg_rd, reg_rvalid, pvalid;
   logic strap_tx_fd, strap_tx_hd, strap_10_fd, strap_10_hd;
   pin_mode_type  pin_mode;
   reg_index_type reg_addr;
   reg_word_type  reg_wdata, reg_rdata, pword, advert_word;
   int num_errors, check_count;
   phy_ident_autoneg_ability_regs #(.OUI_HIGH(OUI_H), .OUI_LOW(OUI_L),
      .MODEL_BASIC(MOD_B), .MODEL_ENHANCED(MOD_E), .REVISION(REV))
   phy_ident_autoneg_ability_regs_i (.core_clk(core_clk), .rst_n(rst_n),
      .pin_mode(pin_mode), .strap_load(strap_load),
      .strap_tx_fd(strap_tx_fd), .strap_tx_hd(strap_tx_hd),
      .strap_10_fd(strap_10_fd), .strap_10_hd(strap_10_hd),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .partner_word_valid(pvalid), .partner_word(pword),
      .advert_word(advert_word));
   link_partner_model link_partner_model_i (.core_clk(core_clk),
      .partner_word_valid(pvalid), .partner_word(pword));
   always #5 core_clk = ~core_clk;
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : results
   task automatic check(string name, reg_word_type seen, reg_word_type exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic chk_rd(reg_index_type a, reg_word_type exp, string name);
      int n;
      n = 0;
      @(posedge core_clk);
      #1;
      reg_rd   = 1'b1;
      reg_addr = a;
      @(posedge core_clk);
      #1;
      reg_rd = 1'b0;
      while (reg_rvalid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (reg_rvalid !== 1'b1) begin
         num_errors++;
         results();
      end else begin
         check(name, reg_rdata, exp);
      end
   endtask : chk_rd
   task automatic wr(reg_index_type a, reg_word_type d);
      @(posedge core_clk);
      #1;
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
   endtask : wr
   task automatic strap(pin_mode_type m, logic v, reg_word_type exp);
      pin_mode = m;
      {strap_tx_fd, strap_tx_hd, strap_10_fd, strap_10_hd} = {4{v}};
      @(posedge core_clk);
      #1;
      strap_load = 1'b1;
      @(posedge core_clk);
      #1;
      strap_load = 1'b0;
      chk_rd(`LOCAL_ADVERT_IDX, exp, "advert_strap");
   endtask : strap
   initial begin
      {core_clk, rst_n, strap_load, reg_wr, reg_rd, reg_addr} = '0;
      {strap_tx_fd, strap_tx_hd, strap_10_fd, strap_10_hd, reg_wdata} = '0;
      pin_mode = PIN_MODE_BASIC;
      repeat (5) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      chk_rd(`IDENT_HIGH_IDX, OUI_H, "ident_high");
      chk_rd(`IDENT_LOW_IDX, {OUI_L, MOD_B, REV}, "ident_low");
      check("advert_word", advert_word, 16'h01e1);
      chk_rd(`LOCAL_ADVERT_IDX, 16'h01e1, "advert");
      chk_rd(`PARTNER_ABIL_IDX, 16'h0000, "partner");
      pin_mode = PIN_MODE_ENHANCED;
      chk_rd(`IDENT_LOW_IDX, {OUI_L, MOD_E, REV}, "ident_low");
      $display("test identity done");
      wr(`LOCAL_ADVERT_IDX, 16'hdfff);
      chk_rd(`LOCAL_ADVERT_IDX, 16'h8dff, "advert");
      check("advert_word", advert_word, 16'h8dff);
      wr(`LOCAL_ADVERT_IDX, 16'h0000);
      chk_rd(`LOCAL_ADVERT_IDX, 16'h0000, "advert");
      for (int i = 2; i < 6; i++) wr(5'(i), 16'hdfff);
      chk_rd(`IDENT_HIGH_IDX, OUI_H, "ident_high");
      chk_rd(`IDENT_LOW_IDX, {OUI_L, MOD_E, REV}, "ident_low");
      chk_rd(`PARTNER_ABIL_IDX, 16'h0000, "partner");
      chk_rd(5'h1f, 16'h0000, "unmapped");
      chk_rd(`LOCAL_ADVERT_IDX, 16'h8dff, "advert_masked");
      wr(`LOCAL_ADVERT_IDX, 16'h0000);
      $display("test writes done");
      strap(PIN_MODE_ENHANCED, 1'b1, 16'h0020);
      strap(PIN_MODE_BASIC, 1'b1, 16'h01e0);
      strap(PIN_MODE_ENHANCED, 1'b0, 16'h01c0);
      strap(PIN_MODE_BASIC, 1'b0, 16'h0000);
      $display("test straps done");
      for (int i = 0; i < 16; i++) begin
         link_partner_model_i.send(16'h0001 << i);
         chk_rd(`PARTNER_ABIL_IDX, (16'h0001 << i) & `PARTNER_ABIL_MASK,
            "partner");
      end
      $display("test partner done");
      rst_n = 1'b0;
      @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      chk_rd(`LOCAL_ADVERT_IDX, 16'h01e1, "advert");
      chk_rd(`PARTNER_ABIL_IDX, 16'h0000, "partner");
      $display("test reset again done");
      results();
   end
endmodule : testbench
